// file: hw/pnpcb_pkg.sv
// Constants and carrier types shared by the PnP configuration bank.
//
// Function
// - Select zero clears PnP registers to zero
// - Select one loads PnP registers with defaults
// - Select changes only when written complemented
// - Pin select swaps disk pins for infrared
// - Address select plus key select choose access
// - Drive select picks totem-pole or open-drain in EPP or ECP mode
// - Floppy legacy bit gates DOR irq bit
// - Printer legacy bit gates PRINTER_DEVICE_CTRL irq bit
// - Serial legacy bits gate modem control bit
// - Joystick select needs base, select, A10
// - Joystick size code picks decoded bytes
// - Floppy decode on A9-A4, low nibble 0xxx
// - Disk control decode on A9-A4, 0xxx
// - Alternate status decode needs nibble 0110
// - Printer decode on A9-A2, EPP, ECP
// - Serial A decode on A9-A3
// - Serial B decode like serial A
// - DMA register routes floppy and printer requests
// - ECP irq field mirrored read-only outward
// - Route field drives one irq output
// - Registers reached only in extended mode
package pnpcb_pkg;
	localparam logic [7:0] IDX_STRAP  = 8'h16;
	localparam logic [7:0] IDX_LEGACY = 8'h17;
	localparam logic [7:0] IDX_JOY    = 8'h1e;
	localparam logic [7:0] IDX_FDC    = 8'h20;
	localparam logic [7:0] IDX_DCTL   = 8'h21;
	localparam logic [7:0] IDX_DALT   = 8'h22;
	localparam logic [7:0] IDX_PTR    = 8'h23;
	localparam logic [7:0] IDX_SERA   = 8'h24;
	localparam logic [7:0] IDX_SERB   = 8'h25;
	localparam logic [7:0] IDX_DMA    = 8'h26;
	localparam logic [7:0] IDX_PIRQ   = 8'h27;

	localparam logic [7:0] DEF_JOY  = 8'h81;
	localparam logic [7:0] DEF_FDC  = 8'hfc;
	localparam logic [7:0] DEF_DCTL = 8'h7c;
	localparam logic [7:0] DEF_DALT = 8'hfd;
	localparam logic [7:0] DEF_PTR  = 8'hde;
	localparam logic [7:0] DEF_SERA = 8'hfe;
	localparam logic [7:0] DEF_SERB = 8'hbe;
	localparam logic [7:0] DEF_DMA  = 8'h23;
	localparam logic [7:0] DEF_PIRQ = 8'h05;
	localparam logic [4:0] RST_LEGACY = 5'h00;

	localparam int BIT_PNP   = 2;
	localparam int BIT_INFRARED_DISK_PIN_SELECT = 1;
	localparam int BIT_PAS   = 0;
	localparam int BIT_PDRV  = 4;
	localparam int BIT_FDIS  = 3;
	localparam int BIT_PDIS  = 2;
	localparam int BIT_SADIS = 1;
	localparam int BIT_SBDIS = 0;

	localparam logic [3:0] NIB_JOY_ONE = 4'h1;
	localparam logic [3:0] NIB_ALT     = 4'h6;
	localparam logic [3:0] ROUTE_MAX   = 4'h8;

	typedef struct packed {
		logic joy;
		logic fdc;
		logic dctl;
		logic dalt;
		logic ptr;
		logic sera;
		logic serb;
	} pnpcb_cs_s;

	// Index 0 is pin 1, 1 is pin 91, 2 is pin 94, 3 is pin 95.
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} pnpcb_pins_s;
endpackage

// file: hw/pnpcb_addr_dec.sv
// Base-address match for one function decoder.
`timescale 1ns/1ps
`default_nettype none
module pnpcb_addr_dec #(
	parameter int MW = 6
) (
	// Programmed base and qualifiers.
	input  wire logic [MW-1:0] base_i,
	input  wire logic          en_i,
	input  wire logic          low_ok_i,
	input  wire logic          a10_free_i,
	// Host address.
	input  wire logic [10:0]   addr_i,
	input  wire logic          cs_n_i,
	// Result.
	output logic               hit_o
);
	if (MW < 1 || MW > 8) begin : g_chk
		$error("pnpcb_addr_dec: MW must be 1 to 8");
	end

	assign hit_o = en_i && low_ok_i && !cs_n_i && (a10_free_i || !addr_i[10])
		&& (base_i == addr_i[9 -: MW]);
endmodule
`default_nettype wire

// file: hw/pnpcb_irq_route.sv
// Steers one interrupt source onto a selected output line.
`timescale 1ns/1ps
`default_nettype none
module pnpcb_irq_route #(
	parameter int N = 8
) (
	// Selection.
	input  wire logic [3:0]   route_i,
	input  wire logic         od_i,
	input  wire logic         irq_i,
	// Lines.
	output logic [N-1:0]      line_o,
	output logic [N-1:0]      oe_o
);
	if (N < 1 || N > 15) begin : g_chk
		$error("pnpcb_irq_route: N must be 1 to 15");
	end

	// Codes past N match no line, so every line stays released.
	for (genvar i = 0; i < N; i++) begin : g_line
		logic sel;
		assign sel = (route_i == 4'(i + 1));
		// Open-drain only pulls low and lets the wire float high.
		assign oe_o[i] = sel && (!od_i || !irq_i);
		assign line_o[i] = irq_i && !od_i;
	end
endmodule
`default_nettype wire

// file: hw/pnpcb_top.sv
// Plug-and-play configuration bank with decoders and resource routing.
`timescale 1ns/1ps
`default_nettype none
module pnpcb_top (
	// Clock and reset.
	input  wire logic                  clock_i,
	input  wire logic                  srst_i,
	// Index and data port access.
	input  wire logic                  efm_i,
	input  wire logic                  idx_wr_i,
	input  wire logic                  dat_wr_i,
	input  wire logic                  dat_rd_i,
	input  wire logic [7:0]            wdata_i,
	output logic [7:0]                 rdata_o,
	// Power-on straps.
	input  wire logic                  strap_pnp_i,
	input  wire logic                  strap_infrared_disk_pin_select_i,
	input  wire logic                  strap_pas_i,
	// Configuration port access mode.
	input  wire logic                  config_enable_key_select_i,
	output logic [1:0]                 ext_access_mode_o,
	// Host address decode.
	input  wire logic [10:0]           addr_i,
	input  wire logic                  chip_select_n_i,
	output pnpcb_pkg::pnpcb_cs_s       dec_sel_o,
	// Printer interrupt.
	input  wire logic                  ptr_irq_i,
	input  wire logic                  ptr_epp_i,
	input  wire logic                  ptr_ecp_i,
	input  wire logic                  printer_device_ctrl_irq_i,
	output logic [5:0]                 irq_line_o,
	output logic [5:0]                 irq_oe_o,
	output logic [2:0]                 ecp_config_b_irq_o,
	// Legacy interrupt gates.
	input  wire logic                  floppy_dor_irq_i,
	input  wire logic                  modem_ctrl_reg_a_irq_i,
	input  wire logic                  modem_ctrl_reg_b_irq_i,
	output logic                       fdc_irq_gate_o,
	output logic                       sera_irq_gate_o,
	output logic                       serb_irq_gate_o,
	// Shared disk and infrared pins.
	input  wire logic                  disk_reset_n_i,
	input  wire logic                  disk_buffer_en_n_i,
	input  wire logic                  disk_select_0_n_i,
	input  wire logic                  disk_select_1_n_i,
	input  wire logic                  infrared_tx_second_i,
	input  wire logic [3:0]            shared_pin_i,
	output pnpcb_pkg::pnpcb_pins_s     shared_o,
	output logic                       infrared_rx_second_o,
	// DMA routing.
	input  wire logic                  floppy_drq_i,
	input  wire logic                  printer_drq_i,
	input  wire logic [2:0]            dack_n_i,
	output logic [2:0]                 drq_o,
	output logic                       floppy_dack_n_o,
	output logic                       printer_dack_n_o
);
	logic [7:0] idx_ff;
	logic [2:0] strap_ff;
	logic [4:0] legacy_ff;
	logic [7:0] joy_ff;
	logic [7:2] fdc_ff;
	logic [7:2] dctl_ff;
	logic [7:2] dalt_ff;
	logic [7:0] ptr_ff;
	logic [7:1] sera_ff;
	logic [7:1] serb_ff;
	logic [7:0] dma_ff;
	logic [2:0] pirq_hi_ff;
	logic [3:0] pirq_lo_ff;
	logic [7:0] rdata_ff;
	logic       wr_hit;
	logic       wr_strap;
	logic       pnp_tgl;
	logic       ld;
	logic       ld_def;
	logic [7:0] rd_val;

	assign wr_hit = efm_i && dat_wr_i;
	assign wr_strap = wr_hit && (idx_ff == pnpcb_pkg::IDX_STRAP);

	assign pnp_tgl = wr_strap && (wdata_i[pnpcb_pkg::BIT_PNP] != strap_ff[pnpcb_pkg::BIT_PNP]);

	// The straps seed the bank at reset exactly as a toggle would later.
	assign ld = srst_i || pnp_tgl;
	assign ld_def = srst_i ? strap_pnp_i : wdata_i[pnpcb_pkg::BIT_PNP];

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			idx_ff <= 8'h00;
		end else if (efm_i && idx_wr_i) begin
			idx_ff <= wdata_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			strap_ff <= {strap_pnp_i, strap_infrared_disk_pin_select_i, strap_pas_i};
		end else if (wr_strap) begin
			strap_ff <= wdata_i[2:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			legacy_ff <= pnpcb_pkg::RST_LEGACY;
		end else if (wr_hit && idx_ff == pnpcb_pkg::IDX_LEGACY) begin
			legacy_ff <= wdata_i[4:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (ld) begin
			joy_ff <= ld_def ? pnpcb_pkg::DEF_JOY : 8'h00;
			fdc_ff <= ld_def ? pnpcb_pkg::DEF_FDC[7:2] : 6'h00;
			dctl_ff <= ld_def ? pnpcb_pkg::DEF_DCTL[7:2] : 6'h00;
			dalt_ff <= ld_def ? pnpcb_pkg::DEF_DALT[7:2] : 6'h00;
			ptr_ff <= ld_def ? pnpcb_pkg::DEF_PTR : 8'h00;
			sera_ff <= ld_def ? pnpcb_pkg::DEF_SERA[7:1] : 7'h00;
			serb_ff <= ld_def ? pnpcb_pkg::DEF_SERB[7:1] : 7'h00;
			dma_ff <= ld_def ? pnpcb_pkg::DEF_DMA : 8'h00;
			pirq_hi_ff <= ld_def ? pnpcb_pkg::DEF_PIRQ[7:5] : 3'h0;
			pirq_lo_ff <= ld_def ? pnpcb_pkg::DEF_PIRQ[3:0] : 4'h0;
		end else if (wr_hit) begin
			case (idx_ff)
				pnpcb_pkg::IDX_JOY: begin
					joy_ff <= wdata_i;
				end
				pnpcb_pkg::IDX_FDC: begin
					fdc_ff <= wdata_i[7:2];
				end
				pnpcb_pkg::IDX_DCTL: begin
					dctl_ff <= wdata_i[7:2];
				end
				pnpcb_pkg::IDX_DALT: begin
					dalt_ff <= wdata_i[7:2];
				end
				pnpcb_pkg::IDX_PTR: begin
					ptr_ff <= wdata_i;
				end
				pnpcb_pkg::IDX_SERA: begin
					sera_ff <= wdata_i[7:1];
				end
				pnpcb_pkg::IDX_SERB: begin
					serb_ff <= wdata_i[7:1];
				end
				pnpcb_pkg::IDX_DMA: begin
					dma_ff <= wdata_i;
				end
				pnpcb_pkg::IDX_PIRQ: begin
					pirq_hi_ff <= wdata_i[7:5];
					pirq_lo_ff <= wdata_i[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rd_val = 8'h00;
		case (idx_ff)
			pnpcb_pkg::IDX_STRAP: rd_val = {5'h00, strap_ff};
			pnpcb_pkg::IDX_LEGACY: rd_val = {3'h0, legacy_ff};
			pnpcb_pkg::IDX_JOY: rd_val = joy_ff;
			pnpcb_pkg::IDX_FDC: rd_val = {fdc_ff, 2'h0};
			pnpcb_pkg::IDX_DCTL: rd_val = {dctl_ff, 2'h0};
			pnpcb_pkg::IDX_DALT: rd_val = {dalt_ff, 2'h1};
			pnpcb_pkg::IDX_PTR: rd_val = ptr_ff;
			pnpcb_pkg::IDX_SERA: rd_val = {sera_ff, 1'h0};
			pnpcb_pkg::IDX_SERB: rd_val = {serb_ff, 1'h0};
			pnpcb_pkg::IDX_DMA: rd_val = dma_ff;
			pnpcb_pkg::IDX_PIRQ: rd_val = {pirq_hi_ff, 1'h0, pirq_lo_ff};
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rdata_ff <= 8'h00;
		end else if (efm_i && dat_rd_i) begin
			rdata_ff <= rd_val;
		end
	end
	assign rdata_o = rdata_ff;

	pnpcb_pkg::pnpcb_cs_s hit;
	logic                 joy_low;
	logic [7:0]           ptr_base;

	always_comb begin
		case (joy_ff[1:0])
			2'h1: joy_low = (addr_i[3:0] == pnpcb_pkg::NIB_JOY_ONE);
			2'h2: joy_low = !addr_i[3];
			2'h3: joy_low = 1'b1;
			default: joy_low = 1'b0;
		endcase
	end

	assign ptr_base = ptr_epp_i ? {ptr_ff[7:1], addr_i[2]} : ptr_ff;

	pnpcb_addr_dec #(.MW(6)) u_joy (
		.base_i     (joy_ff[7:2]),
		.en_i       (joy_ff[1:0] != 2'h0),
		.low_ok_i   (joy_low),
		.a10_free_i (1'b0),
		.addr_i     (addr_i),
		.cs_n_i     (chip_select_n_i),
		.hit_o      (hit.joy)
	);

	pnpcb_addr_dec #(.MW(6)) u_fdc (
		.base_i     (fdc_ff),
		.en_i       (fdc_ff[7:6] != 2'h0),
		.low_ok_i   (!addr_i[3]),
		.a10_free_i (1'b0),
		.addr_i     (addr_i),
		.cs_n_i     (chip_select_n_i),
		.hit_o      (hit.fdc)
	);

	pnpcb_addr_dec #(.MW(6)) u_dctl (
		.base_i     (dctl_ff),
		.en_i       (dctl_ff[7:6] != 2'h0),
		.low_ok_i   (!addr_i[3]),
		.a10_free_i (1'b0),
		.addr_i     (addr_i),
		.cs_n_i     (chip_select_n_i),
		.hit_o      (hit.dctl)
	);

	pnpcb_addr_dec #(.MW(6)) u_dalt (
		.base_i     (dalt_ff),
		.en_i       (dalt_ff[7:6] != 2'h0),
		.low_ok_i   (addr_i[3:0] == pnpcb_pkg::NIB_ALT),
		.a10_free_i (1'b0),
		.addr_i     (addr_i),
		.cs_n_i     (chip_select_n_i),
		.hit_o      (hit.dalt)
	);

	pnpcb_addr_dec #(.MW(8)) u_ptr (
		.base_i     (ptr_base),
		.en_i       (ptr_ff[7:6] != 2'h0),
		.low_ok_i   (1'b1),
		.a10_free_i (ptr_ecp_i),
		.addr_i     (addr_i),
		.cs_n_i     (chip_select_n_i),
		.hit_o      (hit.ptr)
	);

	pnpcb_addr_dec #(.MW(7)) u_sera (
		.base_i     (sera_ff),
		.en_i       (sera_ff[7:6] != 2'h0),
		.low_ok_i   (1'b1),
		.a10_free_i (1'b0),
		.addr_i     (addr_i),
		.cs_n_i     (chip_select_n_i),
		.hit_o      (hit.sera)
	);

	pnpcb_addr_dec #(.MW(7)) u_serb (
		.base_i     (serb_ff),
		.en_i       (serb_ff[7:6] != 2'h0),
		.low_ok_i   (1'b1),
		.a10_free_i (1'b0),
		.addr_i     (addr_i),
		.cs_n_i     (chip_select_n_i),
		.hit_o      (hit.serb)
	);

	logic       ptr_irq_g;
	logic       ptr_od;
	logic [7:0] r_line;
	logic [7:0] r_oe;

	assign ptr_irq_g = ptr_irq_i && (legacy_ff[pnpcb_pkg::BIT_PDIS] || printer_device_ctrl_irq_i);

	assign ptr_od = !legacy_ff[pnpcb_pkg::BIT_PDRV] && (ptr_epp_i || ptr_ecp_i);

	pnpcb_irq_route #(.N(8)) u_route (
		.route_i (pirq_lo_ff),
		.od_i    (ptr_od),
		.irq_i   (ptr_irq_g),
		.line_o  (r_line),
		.oe_o    (r_oe)
	);

	pnpcb_pkg::pnpcb_pins_s pins;
	logic [2:0]             drq;
	logic                   f_dack_n;
	logic                   p_dack_n;

	always_comb begin
		if (strap_ff[pnpcb_pkg::BIT_INFRARED_DISK_PIN_SELECT]) begin
			pins.out = {infrared_tx_second_i, 1'b0, r_line[7], r_line[6]};
			pins.oe = {1'b1, 1'b0, r_oe[7], r_oe[6]};
		end else begin
			pins.out = {disk_select_1_n_i, disk_select_0_n_i, disk_buffer_en_n_i, disk_reset_n_i};
			pins.oe = 4'hf;
		end
	end

	always_comb begin
		drq = 3'h0;
		f_dack_n = 1'b1;
		p_dack_n = 1'b1;
		for (int k = 0; k < 3; k++) begin
			if (dma_ff[7:4] == 4'(k + 1)) begin
				drq[k] = drq[k] | floppy_drq_i;
				f_dack_n = dack_n_i[k];
			end
			if (dma_ff[3:0] == 4'(k + 1)) begin
				drq[k] = drq[k] | printer_drq_i;
				p_dack_n = dack_n_i[k];
			end
		end
	end

	// Everything outward is registered, so each pin lags its cause by one edge.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			dec_sel_o <= '0;
			irq_line_o <= 6'h00;
			irq_oe_o <= 6'h00;
			shared_o <= '0;
			infrared_rx_second_o <= 1'b0;
			drq_o <= 3'h0;
			floppy_dack_n_o <= 1'b1;
			printer_dack_n_o <= 1'b1;
		end else begin
			dec_sel_o <= hit;
			irq_line_o <= r_line[5:0];
			irq_oe_o <= r_oe[5:0];
			shared_o <= pins;
			infrared_rx_second_o <= strap_ff[pnpcb_pkg::BIT_INFRARED_DISK_PIN_SELECT] && shared_pin_i[2];
			drq_o <= drq;
			floppy_dack_n_o <= f_dack_n;
			printer_dack_n_o <= p_dack_n;
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			fdc_irq_gate_o <= 1'b0;
			sera_irq_gate_o <= 1'b0;
			serb_irq_gate_o <= 1'b0;
			ext_access_mode_o <= 2'h0;
			ecp_config_b_irq_o <= 3'h0;
		end else begin
			fdc_irq_gate_o <= legacy_ff[pnpcb_pkg::BIT_FDIS] || floppy_dor_irq_i;
			sera_irq_gate_o <= legacy_ff[pnpcb_pkg::BIT_SADIS] || modem_ctrl_reg_a_irq_i;
			serb_irq_gate_o <= legacy_ff[pnpcb_pkg::BIT_SBDIS] || modem_ctrl_reg_b_irq_i;
			ext_access_mode_o <= {config_enable_key_select_i, strap_ff[pnpcb_pkg::BIT_PAS]};
			ecp_config_b_irq_o <= pirq_hi_ff;
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (srst_i);

	property p_pnp_zero;
		pnp_tgl && !wdata_i[2] |=> joy_ff == 8'h00 && fdc_ff == 6'h00 && pirq_lo_ff == 4'h0;
	endproperty
	a_pnp_zero:
		assert property (p_pnp_zero) else $error("bank not cleared");

	property p_pnp_def;
		pnp_tgl && wdata_i[2] |=> joy_ff == 8'h81 && dma_ff == 8'h23 && ptr_ff == 8'hde;
	endproperty
	a_pnp_def:
		assert property (p_pnp_def) else $error("defaults not loaded");

	property p_pnp_keep;
		wr_strap && wdata_i[2] == strap_ff[2] |=> $stable(joy_ff) && $stable(sera_ff);
	endproperty
	a_pnp_keep:
		assert property (p_pnp_keep) else $error("bank changed without toggle");

	property p_pins_ir;
		strap_ff[1] |=> !shared_o.oe[2] && shared_o.oe[3];
	endproperty
	a_pins_ir:
		assert property (p_pins_ir) else $error("pin 94 driven in infrared mode");

	property p_joy_cs;
		dec_sel_o.joy |-> $past(!chip_select_n_i && !addr_i[10] && joy_ff[1:0] != 2'h0);
	endproperty
	a_joy_cs:
		assert property (p_joy_cs) else $error("joystick select unqualified");

	property p_alt;
		dec_sel_o.dalt |-> $past(addr_i[3:0]) == 4'h6;
	endproperty
	a_alt:
		assert property (p_alt) else $error("alternate status nibble wrong");

	property p_fdc_off;
		fdc_ff[7:6] == 2'h0 |=> !dec_sel_o.fdc;
	endproperty
	a_fdc_off:
		assert property (p_fdc_off) else $error("floppy decode not disabled");

	property p_route_none;
		pirq_lo_ff > 4'h8 || pirq_lo_ff == 4'h0 |=> irq_oe_o == 6'h00;
	endproperty
	a_route_none:
		assert property (p_route_none) else $error("irq driven with no route");

	property p_rd_gate;
		dat_rd_i && !efm_i |=> $stable(rdata_o);
	endproperty
	a_rd_gate:
		assert property (p_rd_gate) else $error("read outside extended mode");

	property p_sera;
		legacy_ff[1] |=> sera_irq_gate_o;
	endproperty
	a_sera:
		assert property (p_sera) else $error("serial A gate not forced");

	c_toggle: cover property (pnp_tgl ##[1:8] pnp_tgl);
	c_joy: cover property (dec_sel_o.joy);
	c_route: cover property (irq_oe_o != 6'h00);
endmodule
`default_nettype wire

// file: tb/pnpcb_host_model.sv
// Host I/O bus model that reaches the bank through the index and data ports.
`timescale 1ns/1ps
`default_nettype none
module pnpcb_host_model (
	// Clock.
	input  wire logic       clock_i,
	// Port strobes and data.
	output logic            efm_o,
	output logic            idx_wr_o,
	output logic            dat_wr_o,
	output logic            dat_rd_o,
	output logic [7:0]      wdata_o,
	input  wire logic [7:0] rdata_i
);
	initial begin
		efm_o = 1'b1;
		{idx_wr_o, dat_wr_o, dat_rd_o} = 3'h0;
		wdata_o = 8'h00;
	end
	task automatic set_mode(input logic m);
		@(negedge clock_i);
		efm_o = m;
	endtask
	// The byte is inverted once the strobe drops, so a stale value never looks valid.
	task automatic pulse(input logic [1:0] kind, input logic [7:0] d);
		@(negedge clock_i);
		wdata_o = d;
		idx_wr_o = (kind == 2'h0);
		dat_wr_o = (kind == 2'h1);
		dat_rd_o = (kind == 2'h2);
		@(negedge clock_i);
		{idx_wr_o, dat_wr_o, dat_rd_o} = 3'h0;
		wdata_o = ~d;
	endtask
	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
		pulse(2'h0, idx);
		pulse(2'h1, d);
	endtask
	task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
		pulse(2'h0, idx);
		pulse(2'h2, 8'h00);
		@(negedge clock_i);
		d = rdata_i;
	endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the PnP configuration bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock_i = 1'b0, srst_i = 1'b1, efm_i, idx_wr_i, dat_wr_i, dat_rd_i;
	logic [7:0] wdata_i, rdata_o;
	logic strap_pnp_i = 1'b1, strap_infrared_disk_pin_select_i = 1'b0, strap_pas_i = 1'b1, config_enable_key_select_i = 1'b1;
	logic [1:0] ext_access_mode_o;
	logic [10:0] addr_i = 11'h000;
	logic chip_select_n_i = 1'b1, ptr_irq_i = 1'b0, ptr_epp_i = 1'b0, ptr_ecp_i = 1'b0;
	logic printer_device_ctrl_irq_i = 1'b1, floppy_dor_irq_i = 1'b0;
	logic modem_ctrl_reg_a_irq_i = 1'b0, modem_ctrl_reg_b_irq_i = 1'b0;
	logic disk_reset_n_i = 1'b1, disk_buffer_en_n_i = 1'b0, disk_select_0_n_i = 1'b1;
	logic disk_select_1_n_i = 1'b0, infrared_tx_second_i = 1'b1, infrared_rx_second_o;
	logic floppy_drq_i = 1'b0, printer_drq_i = 1'b0, floppy_dack_n_o, printer_dack_n_o;
	logic fdc_irq_gate_o, sera_irq_gate_o, serb_irq_gate_o;
	logic [5:0] irq_line_o, irq_oe_o;
	logic [2:0] ecp_config_b_irq_o, drq_o, dack_n_i = 3'h7;
	logic [3:0] ext_pin = 4'h5;
	wire logic [3:0] shared_pin_i;
	pnpcb_pkg::pnpcb_cs_s dec_sel_o;
	pnpcb_pkg::pnpcb_pins_s shared_o;
	int err_count = 0, checked = 0, cyc = 0;
	logic [7:0] sh [7];
	logic [7:0] ix [10] = '{8'h17, 8'h1e, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27};
	logic [7:0] dv [10] = '{8'h00, 8'h81, 8'hfc, 8'h7c, 8'hfd, 8'hde, 8'hfe, 8'hbe, 8'h23, 8'h05};
	logic [7:0] rx [7] = '{8'h17, 8'h20, 8'h21, 8'h22, 8'h24, 8'h25, 8'h27};
	logic [7:0] rm [7] = '{8'h1f, 8'hfc, 8'hfc, 8'hfd, 8'hfe, 8'hfe, 8'hef};
	logic [10:0] al [12] = '{11'h201, 11'h205, 11'h209, 11'h3f6, 11'h3f8, 11'h1f6, 11'h1f8, 11'h378, 11'h37c,
		11'h2f8, 11'h778, 11'h006};
	// Each shared pin is what the bank drives while enabled, otherwise the outside level.
	assign shared_pin_i = (shared_o.oe & shared_o.out) | (~shared_o.oe & ext_pin);
	pnpcb_host_model host (.clock_i, .efm_o(efm_i), .idx_wr_o(idx_wr_i), .dat_wr_o(dat_wr_i),
		.dat_rd_o(dat_rd_i), .wdata_o(wdata_i), .rdata_i(rdata_o));
	pnpcb_top uut (.clock_i, .srst_i, .efm_i, .idx_wr_i, .dat_wr_i, .dat_rd_i, .wdata_i, .rdata_o, .strap_pnp_i,
		.strap_infrared_disk_pin_select_i, .strap_pas_i, .config_enable_key_select_i, .ext_access_mode_o, .addr_i, .chip_select_n_i,
		.dec_sel_o, .ptr_irq_i, .ptr_epp_i, .ptr_ecp_i, .printer_device_ctrl_irq_i, .irq_line_o, .irq_oe_o,
		.ecp_config_b_irq_o, .floppy_dor_irq_i, .modem_ctrl_reg_a_irq_i, .modem_ctrl_reg_b_irq_i,
		.fdc_irq_gate_o, .sera_irq_gate_o, .serb_irq_gate_o, .disk_reset_n_i, .disk_buffer_en_n_i,
		.disk_select_0_n_i, .disk_select_1_n_i, .infrared_tx_second_i, .shared_pin_i, .shared_o,
		.infrared_rx_second_o, .floppy_drq_i, .printer_drq_i, .dack_n_i, .drq_o, .floppy_dack_n_o,
		.printer_dack_n_o);
	always #25 clock_i = ~clock_i;
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			$display("[ERR] %0t run did not finish", $time);
			print_verdict;
		end
	end
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t register read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t output %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] v;
		host.rd_reg(idx, v);
		chk_reg(v, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task automatic do_reset;
		srst_i = 1'b1;
		tick(4);
		srst_i = 1'b0;
		tick(1);
	endtask
	function automatic logic [6:0] dref(input logic [10:0] a, input logic c);
		logic q;
		logic [6:0] r;
		q = !c && !a[10];
		r[6] = q && sh[0][1:0] != 2'h0 && a[9:4] == sh[0][7:2] && (sh[0][1] ? (sh[0][0] || !a[3]) : a[3:0] == 4'h1);
		r[5] = q && sh[1][7:6] != 2'h0 && a[9:4] == sh[1][7:2] && !a[3];
		r[4] = q && sh[2][7:6] != 2'h0 && a[9:4] == sh[2][7:2] && !a[3];
		r[3] = q && sh[3][7:6] != 2'h0 && a[9:4] == sh[3][7:2] && a[3:0] == 4'h6;
		r[2] = !c && (ptr_ecp_i || !a[10]) && sh[4][7:6] != 2'h0 && a[9:3] == sh[4][7:1] && (ptr_epp_i || a[2] == sh[4][0]);
		r[1] = q && sh[5][7:6] != 2'h0 && a[9:3] == sh[5][7:1];
		r[0] = q && sh[6][7:6] != 2'h0 && a[9:3] == sh[6][7:1];
		return r;
	endfunction
	task automatic t_bank;
		do_reset;
		rdc(8'h16, 8'h05);
		chk_out(16'(ext_access_mode_o), 16'h3);
		for (int k = 0; k < 10; k++) rdc(ix[k], dv[k]);
		rdc(8'h30, 8'h00);
		host.wr_reg(8'h16, 8'h01);
		for (int k = 0; k < 10; k++) rdc(ix[k], (k == 4) ? 8'h01 : 8'h00);
		host.wr_reg(8'h1e, 8'h55);
		host.wr_reg(8'h16, 8'h01);
		rdc(8'h1e, 8'h55);
		host.wr_reg(8'h16, 8'h05);
		for (int k = 0; k < 10; k++) rdc(ix[k], dv[k]);
		host.set_mode(1'b0);
		host.wr_reg(8'h1e, 8'h00);
		rdc(8'h1e, 8'h05);
		host.set_mode(1'b1);
		rdc(8'h1e, 8'h81);
		host.wr_reg(8'h16, 8'h04);
		tick(2);
		chk_out(16'(ext_access_mode_o), 16'h2);
		for (int k = 0; k < 7; k++) begin
			host.wr_reg(rx[k], 8'hff);
			rdc(rx[k], rm[k]);
		end
		host.wr_reg(8'h16, 8'h00);
		host.wr_reg(8'h16, 8'h04);
		host.wr_reg(8'h17, 8'h00);
	endtask
	task automatic dec_pass;
		foreach (al[k]) for (int c = 0; c < 2; c++) begin
			addr_i = al[k];
			chip_select_n_i = c[0];
			tick(1);
			chk_out(16'(dec_sel_o), 16'(dref(al[k], c[0])));
		end
	endtask
	task automatic t_decode;
		sh = '{8'h81, 8'hfc, 8'h7c, 8'hfd, 8'hde, 8'hfe, 8'hbe};
		for (int m = 0; m < 4; m++) for (int s = 0; s < 4; s++) begin
			{ptr_epp_i, ptr_ecp_i} = m[1:0];
			sh[0] = {6'h20, s[1:0]};
			host.wr_reg(8'h1e, sh[0]);
			dec_pass;
		end
		host.wr_reg(8'h16, 8'h00);
		sh = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
		dec_pass;
		host.wr_reg(8'h16, 8'h04);
		{ptr_epp_i, ptr_ecp_i} = 2'h0;
	endtask
	task automatic t_gate;
		for (int k = 0; k < 16; k++) begin
			host.wr_reg(8'h17, 8'(k));
			{floppy_dor_irq_i, modem_ctrl_reg_a_irq_i, modem_ctrl_reg_b_irq_i} = {k[0], k[2], k[3]};
			tick(2);
			chk_out(16'({fdc_irq_gate_o, sera_irq_gate_o, serb_irq_gate_o}),
				16'({k[3] | k[0], k[1] | k[2], k[0] | k[3]}));
		end
	endtask
	task automatic t_irq;
		logic [5:0] sel;
		host.wr_reg(8'h17, 8'h14);
		printer_device_ctrl_irq_i = 1'b0;
		ptr_irq_i = 1'b1;
		for (int r = 0; r < 16; r++) begin
			host.wr_reg(8'h27, {r[2:0], 1'b0, r[3:0]});
			tick(2);
			sel = (r >= 1 && r <= 6) ? 6'(1 << (r - 1)) : 6'h00;
			chk_out(16'({irq_oe_o, irq_line_o}), 16'({sel, 6'h3f}));
			chk_out(16'(ecp_config_b_irq_o), 16'(r[2:0]));
		end
		host.wr_reg(8'h17, 8'h00);
		printer_device_ctrl_irq_i = 1'b1;
		host.wr_reg(8'h27, 8'h01);
		ptr_epp_i = 1'b1;
		ptr_irq_i = 1'b0;
		tick(2);
		chk_out(16'({irq_oe_o[0], irq_line_o[0]}), 16'h2);
		ptr_irq_i = 1'b1;
		tick(2);
		chk_out(16'(irq_oe_o), 16'h0);
		ptr_epp_i = 1'b0;
		tick(2);
		chk_out(16'({irq_oe_o[0], irq_line_o[0]}), 16'h3);
	endtask
	task automatic t_pins;
		host.wr_reg(8'h17, 8'h10);
		chk_out(16'({shared_o.oe, shared_o.out}), 16'h00f5);
		host.wr_reg(8'h16, 8'h06);
		for (int r = 7; r < 9; r++) begin
			host.wr_reg(8'h27, 8'(r));
			tick(2);
			chk_out(16'({shared_o.oe, shared_o.out[3], shared_o.out[r - 7], infrared_rx_second_o}),
				16'({2'b10, r == 8, r == 7, 3'b111}));
		end
		ext_pin = 4'h0;
		tick(2);
		chk_out(16'(infrared_rx_second_o), 16'h0);
		host.wr_reg(8'h16, 8'h04);
	endtask
	task automatic t_dma;
		logic [2:0] sel;
		host.wr_reg(8'h17, 8'h0f);
		{floppy_drq_i, printer_drq_i, dack_n_i} = 5'b11000;
		for (int j = 0; j < 2; j++) for (int c = 0; c < 5; c++) begin
			host.wr_reg(8'h26, j ? {4'h0, c[3:0]} : {c[3:0], 4'h0});
			tick(2);
			sel = (c >= 1 && c <= 3) ? 3'(1 << (c - 1)) : 3'h0;
			chk_out(16'({drq_o, floppy_dack_n_o, printer_dack_n_o}),
				16'({sel, j ? 1'b1 : sel == 3'h0, j ? sel == 3'h0 : 1'b1}));
		end
	endtask
	initial begin
		t_bank;
		t_decode;
		t_gate;
		t_irq;
		t_pins;
		t_dma;
		print_verdict;
	end
endmodule
`default_nettype wire
